// [fpgac_pkg.sv]
package fpgac_pkg;
    // Gate count and clock
    localparam int unsigned NGATE    = 9;
    localparam int unsigned CLK_NS   = 50;
    // Pulse sequence delay (least) and fuse pulse width (least), in ns
    localparam int unsigned T_D_NS   = 10000;
    localparam int unsigned T_P_NS   = 300000;
    localparam int unsigned TD_CYC   = (T_D_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TP_CYC   = (T_P_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TMR_W    = 16;
    // Register offsets
    localparam logic [3:0] A_CTRL    = 4'h0;
    localparam logic [3:0] A_POLMASK = 4'h4;
    localparam logic [3:0] A_STATUS  = 4'h8;
    localparam logic [3:0] A_RESULT  = 4'hC;
    // Control and status bit positions
    localparam int unsigned B_PROG   = 0;
    localparam int unsigned B_VERIFY = 1;
    localparam int unsigned B_BUSY   = 0;
    localparam int unsigned B_DONE   = 1;
    localparam int unsigned B_FAIL   = 2;
    // Sequencer states, one-hot
    typedef enum logic [8:0] {
        S_IDLE    = 9'h001,
        S_SETUP   = 9'h002,
        S_RAISE   = 9'h004,
        S_FORCE   = 9'h008,
        S_PULSE   = 9'h010,
        S_HOLD    = 9'h020,
        S_UNFORCE = 9'h040,
        S_VERIFY  = 9'h080,
        S_SAMPLE  = 9'h100
    } fpgac_state_t;
    // Pin drive bundle toward the array
    typedef struct packed {
        logic             vcc_prog;   // Supply at program level
        logic             ce_n;       // Chip enable, high = disabled
        logic             ce_vix;     // Chip enable at program-enable level
        logic             in_dis;     // All inputs held at disable level
        logic [NGATE-1:0] output_force_level; // Force one output
    } fpgac_pins_t;
endpackage

// [fpgac_ctrl.sv]
`timescale 1ns/1ps
// Function
// - program polarities first, one at a time
// - ordered supply, force, pulse, release, restore steps
// - verify with inputs disabled, then enable
// - leave unused output polarity links alone
// - leave all links of unused gates intact
module fpgac_ctrl #(
    parameter int unsigned TP = fpgac_pkg::TP_CYC,  // Fuse pulse cycles
    parameter int unsigned TD = fpgac_pkg::TD_CYC   // Sequence delay cycles
) (
    // Clock and reset
    input  wire logic                     ref_clk_i,
    input  wire logic                     resetn_i,
    // Software register port
    input  wire logic [3:0]               addr_i,
    input  wire logic [31:0]              wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [31:0]              rdata_o,
    // Array pins
    input  wire logic [fpgac_pkg::NGATE-1:0] gate_function_output_i,
    output fpgac_pkg::fpgac_pins_t        pins_o
);
    localparam int unsigned N = fpgac_pkg::NGATE;
    localparam logic [fpgac_pkg::TMR_W-1:0] TD_L = TD[fpgac_pkg::TMR_W-1:0];
    localparam logic [fpgac_pkg::TMR_W-1:0] TP_L = TP[fpgac_pkg::TMR_W-1:0];
    localparam logic [fpgac_pkg::TMR_W-1:0] T_ONE = 16'h0001;

    fpgac_pkg::fpgac_state_t      st_r, st_nxt;      // Sequencer state
    logic [fpgac_pkg::TMR_W-1:0]  tmr_r, tmr_nxt;    // Step timer
    logic [N-1:0]                 mask_r;            // Outputs to make active high
    logic [N-1:0]                 pend_r, pend_nxt;  // Outputs still to program
    logic [N-1:0]                 job_r;             // Snapshot of this run
    logic [N-1:0]                 result_r;          // Last sensed outputs
    logic                         prog_r;            // Run includes fusing
    logic                         done_r, fail_r;    // Sticky run status
    logic [N-1:0]                 s1_r, s2_r, s3_r;  // Output sense synchroniser
    logic [N-1:0]                 sense_r;           // Debounced sense
    fpgac_pkg::fpgac_pins_t       pins_r;            // Registered pin drive

    // Decode of the register port
    wire          busy     = (st_r != fpgac_pkg::S_IDLE);
    wire          wr_ctrl  = wr_i && (addr_i == fpgac_pkg::A_CTRL);
    wire          wr_mask  = wr_i && (addr_i == fpgac_pkg::A_POLMASK);
    wire          go_prog  = wr_ctrl && wdata_i[fpgac_pkg::B_PROG] && !busy;
    wire          go_ver   = wr_ctrl && wdata_i[fpgac_pkg::B_VERIFY] && !busy;
    wire          tmr_zero = (tmr_r == '0);
    // Lowest pending output, so only one is fused at a time
    wire [N-1:0]  cur      = pend_r & (~pend_r + T_ONE[N-1:0]);
    wire          last     = ((pend_r & ~cur) == '0);
    wire [31:0]   rd_mux   =
        (addr_i == fpgac_pkg::A_CTRL)    ? {31'h0, busy} :
        (addr_i == fpgac_pkg::A_POLMASK) ? {{(32-N){1'b0}}, mask_r} :
        (addr_i == fpgac_pkg::A_STATUS)  ? {29'h0, fail_r, done_r, busy} :
        (addr_i == fpgac_pkg::A_RESULT)  ? {{(32-N){1'b0}}, result_r} : 32'h0;

    // Next state and step timer
    always_comb begin
        st_nxt   = st_r;
        tmr_nxt  = tmr_zero ? tmr_r : tmr_r - T_ONE;
        pend_nxt = pend_r;
        case (st_r)
            fpgac_pkg::S_IDLE: begin
                if (go_prog || go_ver) begin
                    st_nxt  = fpgac_pkg::S_SETUP;
                    tmr_nxt = TD_L;
                end
            end
            fpgac_pkg::S_SETUP: begin
                // Verify only, or nothing to fuse: go straight to sensing
                if (tmr_zero) begin
                    st_nxt  = (prog_r && pend_r != '0) ? fpgac_pkg::S_RAISE
                                                       : fpgac_pkg::S_VERIFY;
                    tmr_nxt = TD_L;
                end
            end
            fpgac_pkg::S_RAISE: begin
                if (tmr_zero) begin
                    st_nxt  = fpgac_pkg::S_FORCE;
                    tmr_nxt = TD_L;
                end
            end
            fpgac_pkg::S_FORCE: begin
                if (tmr_zero) begin
                    st_nxt  = fpgac_pkg::S_PULSE;
                    tmr_nxt = TP_L;
                end
            end
            fpgac_pkg::S_PULSE: begin
                if (tmr_zero) begin
                    st_nxt  = fpgac_pkg::S_HOLD;
                    tmr_nxt = TD_L;
                end
            end
            fpgac_pkg::S_HOLD: begin
                if (tmr_zero) begin
                    st_nxt  = fpgac_pkg::S_UNFORCE;
                    tmr_nxt = TD_L;
                end
            end
            fpgac_pkg::S_UNFORCE: begin
                if (tmr_zero) begin
                    st_nxt   = fpgac_pkg::S_VERIFY;
                    tmr_nxt  = TD_L;
                    pend_nxt = last ? '0 : pend_r & ~cur;
                end
            end
            fpgac_pkg::S_VERIFY: begin
                // Enable waits a full delay so sensing settles
                if (tmr_zero) begin
                    st_nxt = fpgac_pkg::S_SAMPLE;
                end
            end
            fpgac_pkg::S_SAMPLE: begin
                if (prog_r && pend_r != '0) begin
                    st_nxt  = fpgac_pkg::S_SETUP;
                    tmr_nxt = TD_L;
                end else begin
                    st_nxt  = fpgac_pkg::S_IDLE;
                end
            end
            default: begin
                st_nxt = fpgac_pkg::S_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            st_r   <= fpgac_pkg::S_IDLE;
            tmr_r  <= '0;
            pend_r <= '0;
            job_r  <= '0;
            prog_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            tmr_r  <= tmr_nxt;
            pend_r <= go_prog ? mask_r : pend_nxt;
            job_r  <= go_prog ? mask_r : (go_ver ? '0 : job_r);
            prog_r <= go_prog ? 1'b1 : (go_ver ? 1'b0 : prog_r);
        end
    end

    // Pin drive: every pin decided per state, registered
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pins_r <= '{vcc_prog: 1'b0, ce_n: 1'b1, ce_vix: 1'b0, in_dis: 1'b0,
                        output_force_level: '0};
        end else begin
            pins_r.vcc_prog <= (st_nxt == fpgac_pkg::S_RAISE) ||
                               (st_nxt == fpgac_pkg::S_FORCE) ||
                               (st_nxt == fpgac_pkg::S_PULSE) ||
                               (st_nxt == fpgac_pkg::S_HOLD)  ||
                               (st_nxt == fpgac_pkg::S_UNFORCE);
            pins_r.ce_n     <= !((st_nxt == fpgac_pkg::S_VERIFY) ||
                                 (st_nxt == fpgac_pkg::S_SAMPLE));
            pins_r.ce_vix   <= (st_nxt == fpgac_pkg::S_PULSE);
            pins_r.in_dis   <= (st_nxt != fpgac_pkg::S_IDLE);
            pins_r.output_force_level <=
                ((st_nxt == fpgac_pkg::S_FORCE) || (st_nxt == fpgac_pkg::S_PULSE) ||
                 (st_nxt == fpgac_pkg::S_HOLD)) ? cur : '0;
        end
    end

    // Three-stage sense, change taken once stages two and three agree
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            sense_r <= '0;
        end else begin
            s1_r    <= gate_function_output_i;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            sense_r <= (s2_r == s3_r) ? s3_r : sense_r;
        end
    end

    // Software registers; failure if a fused output still reads low
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            mask_r   <= '0;
            result_r <= '0;
            done_r   <= 1'b0;
            fail_r   <= 1'b0;
            rdata_o  <= '0;
        end else begin
            mask_r  <= wr_mask ? wdata_i[N-1:0] : mask_r;
            rdata_o <= rd_i ? rd_mux : 32'h0;
            if (st_r == fpgac_pkg::S_SAMPLE) begin
                result_r <= sense_r;
                // Only outputs already fused are judged; later ones still read low
                fail_r   <= fail_r || ((job_r & ~pend_r & ~sense_r) != '0);
                done_r   <= !(prog_r && pend_r != '0);
            end else if (go_prog || go_ver) begin
                done_r <= 1'b0;
                fail_r <= 1'b0;
            end
        end
    end

    assign pins_o = pins_r;

    // Helper: length of the current fuse pulse
    logic [fpgac_pkg::TMR_W-1:0] plen_r;
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            plen_r <= '0;
        end else begin
            plen_r <= pins_r.ce_vix ? plen_r + T_ONE : '0;
        end
    end

    AST_ONE_FORCE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $onehot0(pins_r.output_force_level))
        else $error("more than one output forced");
    AST_FORCE_IN_JOB: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (pins_r.output_force_level & ~job_r) == '0)
        else $error("output outside polarity mask forced");
    AST_PULSE_SETUP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        pins_r.ce_vix |-> pins_r.vcc_prog && pins_r.in_dis && pins_r.ce_n
                          && (pins_r.output_force_level != '0))
        else $error("fuse pulse without supply, force or disabled inputs");
    AST_PULSE_LEN: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(pins_r.ce_vix) |-> plen_r == TP_L + T_ONE)
        else $error("fuse pulse width wrong");
    AST_FORCE_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $fell(pins_r.ce_vix) |-> (pins_r.output_force_level != '0) [*2])
        else $error("force removed too soon after pulse");
    AST_VERIFY_PINS: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !pins_r.ce_n |-> pins_r.in_dis && !pins_r.vcc_prog
                         && (pins_r.output_force_level == '0))
        else $error("verify enable with wrong pin state");
    AST_NO_UNUSED: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (st_r == fpgac_pkg::S_IDLE) |-> (pins_r.output_force_level == '0) && !pins_r.vcc_prog)
        else $error("links touched while idle");
endmodule

// [fpgac_array_model.sv]
`timescale 1ns/1ps
// Behavioural gate array: polarity links only, input matrix left blank
module fpgac_array_model #(
    parameter int unsigned TP = 8  // Least fuse pulse cycles
) (
    // Clock for pulse timing and protocol error capture
    input  wire logic                        ref_clk_i,
    // Pins from controller
    input  wire fpgac_pkg::fpgac_pins_t      pins_i,
    input  wire logic [fpgac_pkg::NGATE-1:0] stuck_i,  // Links that refuse to blow
    // Sensed outputs and protocol flag
    output logic [fpgac_pkg::NGATE-1:0]      gate_function_output_o,
    output logic                             rule_err_o
);
    logic                        err_r      = 1'b0;  // Sticky protocol error
    logic [fpgac_pkg::NGATE-1:0] pol_hi_r   = '0;    // Blank is active low
    int unsigned                 pw_cnt     = 0;     // Pulse length so far
    logic                        bad_force;          // Force without supply or disabled inputs, or not one-hot
    assign rule_err_o = err_r;
    assign bad_force = (pins_i.output_force_level != '0) &&
        (!pins_i.vcc_prog || !pins_i.in_dis || !$onehot(pins_i.output_force_level));
    // Disabled inputs make every product true, else the blank null term is false
    assign gate_function_output_o = pins_i.ce_n ? '1 :  // Inhibited output pulled high
        (pins_i.in_dis ? pol_hi_r : ~pol_hi_r);
    // Pulse timing and one-way link removal
    always @(posedge ref_clk_i) begin
        if (bad_force) begin
            err_r <= 1'b1;
        end
        if (pins_i.ce_vix) begin
            pw_cnt <= pw_cnt + 1;
        end else begin
            if (pw_cnt != 0) begin
                // Short pulse or no target blows nothing
                if (pw_cnt < TP || pins_i.output_force_level == '0) begin
                    err_r <= 1'b1;
                end else begin
                    // Links only go from intact to removed
                    pol_hi_r <= pol_hi_r | (pins_i.output_force_level & ~stuck_i);
                end
            end
            pw_cnt <= 0;
        end
    end
endmodule

// [fpgac_ctrl_test.sv]
`timescale 1ns/1ps
// Self-checking bench for the fuse programming controller
module fpgac_ctrl_test;
    logic        ref_clk_i = 1'b0;  // 20 MHz clock
    logic        resetn_i  = 1'b0;  // Held low at start
    logic [3:0]  addr_i    = 4'h0;
    logic [31:0] wdata_i   = 32'h0;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [31:0] rdata_o;
    logic [8:0]  fout;               // Array outputs
    logic [8:0]  stuck     = 9'h000; // Weak links in the model
    logic        rule_err;
    fpgac_pkg::fpgac_pins_t pins_o;
    int          error_cnt   = 0;
    int          check_count = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    fpgac_ctrl #(.TP(8), .TD(6)) i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .gate_function_output_i(fout), .pins_o(pins_o));
    fpgac_array_model #(.TP(8)) i_model (.ref_clk_i(ref_clk_i), .pins_i(pins_o),
        .stuck_i(stuck), .gate_function_output_o(fout), .rule_err_o(rule_err));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    // Read; data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // Start a job, poll until idle, judge status, result and idle pins
    task automatic run_job(input logic [31:0] ctl, input logic [8:0] res, input logic fl);
        logic [31:0] d;
        wr(fpgac_pkg::A_CTRL, ctl);
        wr(fpgac_pkg::A_CTRL, 32'h1);  // Start while busy is ignored
        d = 32'h1;
        for (int i = 0; i < 3000 && d[fpgac_pkg::B_BUSY] !== 1'b0; i++) rd(fpgac_pkg::A_STATUS, d);
        chk(d, (32'h1 << fpgac_pkg::B_DONE) | (32'(fl) << fpgac_pkg::B_FAIL));
        rd(fpgac_pkg::A_RESULT, d);
        chk(d, {23'h0, res});
        chk(32'(pins_o), 32'h0800);  // Supply restored, disabled, no force
        chk(32'(rule_err), 32'h0);
    endtask
    // Reset values and an unmapped read
    task automatic t_reset();
        logic [31:0] d;
        chk(32'(pins_o), 32'h0800);
        rd(fpgac_pkg::A_POLMASK, d); chk(d, 32'h0);
        rd(fpgac_pkg::A_STATUS, d);  chk(d, 32'h0);
        rd(4'h2, d);                 chk(d, 32'h0);
    endtask
    // Blank array verifies all active low
    task automatic t_verify_blank();
        run_job(32'h2, 9'h000, 1'b0);
    endtask
    // Program three outputs including both ends
    task automatic t_program();
        logic [31:0] d;
        wr(fpgac_pkg::A_POLMASK, 32'hFFFF_F105);
        rd(fpgac_pkg::A_POLMASK, d);
        chk(d, 32'h105);
        run_job(32'h1, 9'h105, 1'b0);
    endtask
    // A link that will not blow reports failure, earlier links persist
    task automatic t_fault();
        stuck <= 9'h010;
        wr(fpgac_pkg::A_POLMASK, 32'h018);
        run_job(32'h3, 9'h10D, 1'b1);
        run_job(32'h2, 9'h10D, 1'b0);  // Verify-only judges no job
    endtask
    // Verdict, shared by the main sequence and the watchdog
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_verify_blank();
        t_program();
        t_fault();
        end_of_test();
    end
    // Watchdog well past the expected few hundred cycles
    initial begin
        #1000000;
        error_cnt++;
        end_of_test();
    end
endmodule
